// [tv_filter_pkg.sv]
package tv_filter_pkg;

  // ********************************
  // register map
  // ********************************
  localparam logic [7:0] MODE_REG_ADDR      = 8'h00;
  localparam logic [7:0] FLICKER_REG_ADDR   = 8'h01;
  localparam logic [7:0] BANDWIDTH_REG_ADDR = 8'h02;
  localparam logic [7:0] MODE_RESET         = 8'h6A;
  localparam logic [7:0] FLICKER_RESET      = 8'h27;
  localparam logic [7:0] BANDWIDTH_RESET    = 8'h1E;
  localparam logic [7:0] FLICKER_MASK       = 8'h7F;

  // ********************************
  // field positions
  // ********************************
  localparam int SR_LSB       = 0;
  localparam int VOS_LSB      = 3;
  localparam int IR_LSB       = 5;
  localparam int NONTEXT_LSB  = 0;
  localparam int TEXT_LSB     = 2;
  localparam int CHROMA_LSB   = 4;
  localparam int FORMAT_BIT   = 6;
  localparam int CV_LSB       = 0;
  localparam int SV_LSB       = 2;
  localparam int CBW_BIT      = 4;
  localparam int ROUTE_BIT    = 5;
  localparam int LOCK_BIT     = 6;
  localparam int DEFEAT_BIT   = 7;

  // ********************************
  // stream sizing
  // ********************************
  localparam int FIFO_DEPTH_DEF = 8;
  localparam int SAMPLE_W       = 10;
  localparam int ACC_W          = 12;
  localparam int NUM_FILT       = 4;

  typedef enum logic [1:0] {STD_PAL, STD_NTSC, STD_PAL_M, STD_NTSC_J} video_std_t;
  typedef enum logic [2:0] {RC_54, RC_STD, RC_58, RC_59, RC_HALF} ratio_class_t;

  typedef struct packed {
    logic        [SAMPLE_W-1:0] y;
    logic signed [SAMPLE_W-1:0] cb;
    logic signed [SAMPLE_W-1:0] cr;
    logic                       text;
    logic                       vblank;
    logic                       field_start;
  } pixel_t;

  typedef struct packed {
    logic [SAMPLE_W-1:0] ch0;
    logic [SAMPLE_W-1:0] ch1;
    logic [SAMPLE_W-1:0] ch2;
  } dac_t;

endpackage : tv_filter_pkg

// [stream_fifo.sv]
`timescale 1ns/1ps
module stream_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_nrst,
  // fill side
  input  wire logic [WIDTH-1:0] i_data,
  input  wire logic             i_valid,
  output logic                  o_ready,
  // drain side
  output logic [WIDTH-1:0]      o_data,
  output logic                  o_valid,
  input  wire logic             i_ready
);

  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  generate
    if (DEPTH < 2)
    begin : g_bad_depth
      $error("stream_fifo depth must be at least 2");
    end
  endgenerate

  logic [WIDTH-1:0] mem_r   [DEPTH];
  logic [WIDTH-1:0] mem_nxt [DEPTH];
  logic [PW-1:0]    wr_r, wr_nxt, rd_r, rd_nxt;
  logic [CW-1:0]    cnt_r, cnt_nxt;
  logic             rdy_r, rdy_nxt, val_r, val_nxt;
  logic             push, pop;

  // ********************************
  // pointer and storage update
  // ********************************
  always_comb
  begin
    push    = i_valid && rdy_r;
    pop     = val_r && i_ready;
    mem_nxt = mem_r;
    wr_nxt  = wr_r;
    rd_nxt  = rd_r;
    if (push)
    begin
      mem_nxt[wr_r] = i_data;
      wr_nxt        = (wr_r == PW'(DEPTH - 1)) ? '0 : wr_r + 1'b1;
    end
    if (pop)
    begin
      rd_nxt = (rd_r == PW'(DEPTH - 1)) ? '0 : rd_r + 1'b1;
    end
    cnt_nxt = cnt_r + CW'(push) - CW'(pop);
    // registered flags keep both handshakes free of combinational paths
    rdy_nxt = cnt_nxt != CW'(DEPTH);
    val_nxt = cnt_nxt != '0;
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      for (int i = 0; i < DEPTH; i++)
      begin
        mem_r[i] <= '0;
      end
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
      rdy_r <= 1'b0;
      val_r <= 1'b0;
    end
    else
    begin
      mem_r <= mem_nxt;
      wr_r  <= wr_nxt;
      rd_r  <= rd_nxt;
      cnt_r <= cnt_nxt;
      rdy_r <= rdy_nxt;
      val_r <= val_nxt;
    end
  end

  assign o_ready = rdy_r;
  assign o_valid = val_r;
  assign o_data  = mem_r[rd_r];

endmodule : stream_fifo

// [tv_flicker_bandwidth_control.sv]
`timescale 1ns/1ps
module tv_flicker_bandwidth_control #(
  parameter int FIFO_DEPTH = tv_filter_pkg::FIFO_DEPTH_DEF
) (
  // clock and reset
  input  wire logic                      i_clk,
  input  wire logic                      i_nrst,
  // decoded serial register port
  input  wire logic                      i_reg_wr,
  input  wire logic [7:0]                i_reg_addr,
  input  wire logic [7:0]                i_reg_wdata,
  output logic [7:0]                     o_reg_rdata,
  // pixel stream in
  input  wire tv_filter_pkg::pixel_t     i_pix,
  input  wire logic                      i_pix_valid,
  output logic                           o_pix_ready,
  // dac stream out
  output tv_filter_pkg::dac_t            o_dac,
  output logic                           o_dac_valid,
  input  wire logic                      i_dac_ready,
  // active settings of the sample on o_dac
  output tv_filter_pkg::video_std_t      o_video_std,
  output logic                           o_rgb_mode,
  output logic [2:0]                     o_luma_taps,
  output logic [2:0]                     o_chroma_taps,
  output logic                           o_dot_crawl,
  output logic                           o_subcarrier_locked
);
  import tv_filter_pkg::*;

  default clocking cb_main @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  generate
    if (FIFO_DEPTH < 2)
    begin : g_bad_depth
      $error("fifo depth must be at least 2");
    end
  endgenerate

  // ********************************
  // decode helpers
  // ********************************
  function automatic ratio_class_t ratio_of(input logic [7:0] mode);
    logic big;
    big = mode[IR_LSB +: 3] == 3'h7;
    case (mode[SR_LSB +: 3])
      3'h0:    ratio_of = RC_54;
      3'h5:    ratio_of = RC_58;
      3'h6:    ratio_of = big ? RC_59 : RC_STD;
      3'h7:    ratio_of = big ? RC_HALF : RC_STD;
      default: ratio_of = RC_STD;
    endcase
  endfunction : ratio_of

  function automatic logic [2:0] taps_of(input ratio_class_t rc, input logic [1:0] sel, input logic chroma);
    case (rc)
      RC_54:   taps_of = (sel == 2'h0) ? 3'h2 : 3'h3;
      RC_58:   taps_of = (sel == 2'h3) ? (chroma ? 3'h5 : 3'h6) : 3'h2 + {1'b0, sel};
      RC_59:   taps_of = 3'h3 + {1'b0, sel};
      RC_HALF: taps_of = (sel == 2'h0) ? 3'h3 : (sel == 2'h3) ? 3'h7 : 3'h5;
      default: taps_of = 3'h2 + {1'b0, sel};
    endcase
  endfunction : taps_of

  // wider setting means a smaller shift and so a higher corner frequency
  function automatic logic [1:0] luma_shift(input logic [1:0] sel);
    luma_shift = 2'h3 - sel;
  endfunction : luma_shift

  function automatic logic [SAMPLE_W-1:0] clamp(input logic signed [ACC_W:0] v);
    if (v < 0)
      clamp = '0;
    else if (v > 13'sh03FF)
      clamp = 10'h3FF;
    else
      clamp = v[SAMPLE_W-1:0];
  endfunction : clamp

  // ********************************
  // input buffer
  // ********************************
  pixel_t fifo_pix;
  logic   fifo_valid, fifo_rdy, take, fs_take;
  logic   dac_valid_r, dac_valid_nxt;

  stream_fifo #(.WIDTH($bits(pixel_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_clk   (i_clk),
    .i_nrst  (i_nrst),
    .i_data  (i_pix),
    .i_valid (i_pix_valid),
    .o_ready (o_pix_ready),
    .o_data  (fifo_pix),
    .o_valid (fifo_valid),
    .i_ready (fifo_rdy)
  );

  assign fifo_rdy = !dac_valid_r || i_dac_ready;
  assign take     = fifo_valid && fifo_rdy;
  assign fs_take  = take && fifo_pix.field_start;

  // ********************************
  // registers and field shadows
  // ********************************
  logic [7:0] mode_r, mode_nxt, ff_r, ff_nxt, bw_r, bw_nxt;
  logic [7:0] act_mode_r, act_mode_nxt, act_ff_r, act_ff_nxt, act_bw_r, act_bw_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic [7:0] eff_mode, eff_ff, eff_bw;

  always_comb
  begin
    mode_nxt = mode_r;
    ff_nxt   = ff_r;
    bw_nxt   = bw_r;
    if (i_reg_wr)
    begin
      case (i_reg_addr)
        MODE_REG_ADDR:      mode_nxt = i_reg_wdata;
        FLICKER_REG_ADDR:   ff_nxt   = i_reg_wdata & FLICKER_MASK;
        BANDWIDTH_REG_ADDR: bw_nxt   = i_reg_wdata;
        default:            mode_nxt = mode_r;
      endcase
    end
    case (i_reg_addr)
      MODE_REG_ADDR:      rdata_nxt = mode_r;
      FLICKER_REG_ADDR:   rdata_nxt = ff_r;
      BANDWIDTH_REG_ADDR: rdata_nxt = bw_r;
      default:            rdata_nxt = 8'h00;
    endcase
    // a field always runs on one coefficient set; writes wait for the next field
    act_mode_nxt = fs_take ? mode_r : act_mode_r;
    act_ff_nxt   = fs_take ? ff_r : act_ff_r;
    act_bw_nxt   = fs_take ? bw_r : act_bw_r;
    eff_mode     = fs_take ? mode_r : act_mode_r;
    eff_ff       = fs_take ? ff_r : act_ff_r;
    eff_bw       = fs_take ? bw_r : act_bw_r;
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      mode_r     <= MODE_RESET;
      ff_r       <= FLICKER_RESET;
      bw_r       <= BANDWIDTH_RESET;
      act_mode_r <= MODE_RESET;
      act_ff_r   <= FLICKER_RESET;
      act_bw_r   <= BANDWIDTH_RESET;
      rdata_r    <= 8'h00;
    end
    else
    begin
      mode_r     <= mode_nxt;
      ff_r       <= ff_nxt;
      bw_r       <= bw_nxt;
      act_mode_r <= act_mode_nxt;
      act_ff_r   <= act_ff_nxt;
      act_bw_r   <= act_bw_nxt;
      rdata_r    <= rdata_nxt;
    end
  end

  assign o_reg_rdata = rdata_r;

  // ********************************
  // chroma prefilter and subcarrier
  // ********************************
  logic signed [SAMPLE_W-1:0] prev_cb_r, prev_cb_nxt, prev_cr_r, prev_cr_nxt;
  logic [1:0]                 phase_r, phase_nxt, cur_phase;
  logic                       alt_r, alt_nxt, dot_en;
  logic signed [ACC_W-1:0]    fx [NUM_FILT];
  logic [1:0]                 fk [NUM_FILT];
  logic signed [ACC_W-1:0]    filt [NUM_FILT];
  video_std_t                 std_eff;

  always_comb
  begin
    std_eff = video_std_t'(eff_mode[VOS_LSB +: 2]);
    // blanking defeat drops chroma to its minimum setting, so dot-crawl averaging stops too
    dot_en  = eff_ff[CHROMA_LSB +: 2] == 2'h3 && !(eff_bw[DEFEAT_BIT] && fifo_pix.vblank);
    fx[0]   = {2'h0, fifo_pix.y};
    fx[1]   = {2'h0, fifo_pix.y};
    fx[2]   = dot_en ? ACC_W'((ACC_W'(fifo_pix.cb) + ACC_W'(prev_cb_r)) >>> 1) : ACC_W'(fifo_pix.cb);
    fx[3]   = dot_en ? ACC_W'((ACC_W'(fifo_pix.cr) + ACC_W'(prev_cr_r)) >>> 1) : ACC_W'(fifo_pix.cr);
    fk[0]   = luma_shift(eff_bw[CV_LSB +: 2]);
    fk[1]   = luma_shift(eff_bw[SV_LSB +: 2]);
    fk[2]   = eff_bw[CBW_BIT] ? 2'h1 : 2'h2;
    fk[3]   = fk[2];
    // locked subcarrier restarts at every field, free-running one never does
    cur_phase   = (fs_take && eff_bw[LOCK_BIT]) ? 2'h0 : phase_r;
    phase_nxt   = take ? cur_phase + 2'h1 : phase_r;
    alt_nxt     = fs_take ? !alt_r : alt_r;
    prev_cb_nxt = take ? fifo_pix.cb : prev_cb_r;
    prev_cr_nxt = take ? fifo_pix.cr : prev_cr_r;
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      phase_r   <= 2'h0;
      alt_r     <= 1'b0;
      prev_cb_r <= '0;
      prev_cr_r <= '0;
    end
    else
    begin
      phase_r   <= phase_nxt;
      alt_r     <= alt_nxt;
      prev_cb_r <= prev_cb_nxt;
      prev_cr_r <= prev_cr_nxt;
    end
  end

  // ********************************
  // bandwidth low-pass filters
  // ********************************
  // one-pole filters: cheap, but corners only track the table in steps
  for (genvar g = 0; g < NUM_FILT; g++)
  begin : g_lp
    logic signed [ACC_W-1:0] acc_r, acc_nxt;
    logic signed [ACC_W:0]   diff;
    always_comb
    begin
      diff    = {fx[g][ACC_W-1], fx[g]} - {acc_r[ACC_W-1], acc_r};
      acc_nxt = take ? acc_r + ACC_W'(diff >>> fk[g]) : acc_r;
    end
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
      if (!i_nrst)
        acc_r <= '0;
      else
        acc_r <= acc_nxt;
    end
    assign filt[g] = acc_nxt;
  end

  // ********************************
  // output stage
  // ********************************
  dac_t                  dac_r, dac_nxt;
  video_std_t            std_r, std_nxt;
  logic                  rgb_r, rgb_nxt, dot_r, dot_nxt, lock_r, lock_nxt;
  logic [2:0]            ltap_r, ltap_nxt, ctap_r, ctap_nxt, min_luma_taps;
  logic signed [ACC_W:0] chroma, cr_sgn;
  logic [1:0]            lsel, csel;
  ratio_class_t          rc;

  always_comb
  begin
    rc     = ratio_of(eff_mode);
    cr_sgn = ((std_eff == STD_PAL || std_eff == STD_PAL_M) && alt_r) ? -(ACC_W+1)'(filt[3]) : (ACC_W+1)'(filt[3]);
    case (cur_phase)
      2'h0:    chroma = (ACC_W+1)'(filt[2]);
      2'h1:    chroma = cr_sgn;
      2'h2:    chroma = -(ACC_W+1)'(filt[2]);
      default: chroma = -cr_sgn;
    endcase
    lsel = fifo_pix.text ? eff_ff[TEXT_LSB +: 2] : eff_ff[NONTEXT_LSB +: 2];
    csel = eff_ff[CHROMA_LSB +: 2];
    if (eff_bw[DEFEAT_BIT] && fifo_pix.vblank)
    begin
      lsel = 2'h0;
      csel = 2'h0;
    end
    min_luma_taps = taps_of(rc, 2'h0, 1'b0);
    dac_valid_nxt = take ? 1'b1 : (i_dac_ready ? 1'b0 : dac_valid_r);
    dac_nxt       = dac_r;
    std_nxt       = std_r;
    rgb_nxt       = rgb_r;
    dot_nxt       = dot_r;
    lock_nxt      = lock_r;
    ltap_nxt      = ltap_r;
    ctap_nxt      = ctap_r;
    if (take)
    begin
      std_nxt  = std_eff;
      rgb_nxt  = eff_ff[FORMAT_BIT];
      dot_nxt  = dot_en;
      lock_nxt = eff_bw[LOCK_BIT];
      ltap_nxt = taps_of(rc, lsel, 1'b0);
      ctap_nxt = taps_of(rc, csel, 1'b1);
      if (eff_ff[FORMAT_BIT])
      begin
        dac_nxt.ch0 = fifo_pix.y;
        dac_nxt.ch1 = fifo_pix.cb;
        dac_nxt.ch2 = fifo_pix.cr;
      end
      else
      begin
        dac_nxt.ch1 = clamp({filt[1][ACC_W-1], filt[1]});
        dac_nxt.ch2 = clamp(chroma + 13'sh0200);
        if (eff_bw[ROUTE_BIT])
          dac_nxt.ch0 = clamp({filt[0][ACC_W-1], filt[0]} + chroma);
        else
          dac_nxt.ch0 = clamp({filt[1][ACC_W-1], filt[1]});
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      dac_valid_r <= 1'b0;
      dac_r       <= '0;
      std_r       <= STD_PAL;
      rgb_r       <= 1'b0;
      dot_r       <= 1'b0;
      lock_r      <= 1'b0;
      ltap_r      <= 3'h2;
      ctap_r      <= 3'h2;
    end
    else
    begin
      dac_valid_r <= dac_valid_nxt;
      dac_r       <= dac_nxt;
      std_r       <= std_nxt;
      rgb_r       <= rgb_nxt;
      dot_r       <= dot_nxt;
      lock_r      <= lock_nxt;
      ltap_r      <= ltap_nxt;
      ctap_r      <= ctap_nxt;
    end
  end

  assign o_dac               = dac_r;
  assign o_dac_valid         = dac_valid_r;
  assign o_video_std         = std_r;
  assign o_rgb_mode          = rgb_r;
  assign o_luma_taps         = ltap_r;
  assign o_chroma_taps       = ctap_r;
  assign o_dot_crawl         = dot_r;
  assign o_subcarrier_locked = lock_r;

  // ********************************
  // checks
  // ********************************
  sequence s_field_take;
    fs_take;
  endsequence

  sequence s_stall;
    dac_valid_r && !i_dac_ready;
  endsequence

  property p_std_decode;
    take |=> o_video_std == video_std_t'($past(eff_mode[VOS_LSB +: 2]));
  endproperty
  a_std_decode: assert property (p_std_decode) else $error("standard not decoded");

  property p_field_load;
    s_field_take |=> act_ff_r == $past(ff_r) && act_bw_r == $past(bw_r);
  endproperty
  a_field_load: assert property (p_field_load) else $error("settings not loaded at field");

  property p_mid_field;
    !fs_take |=> $stable(act_ff_r) && $stable(act_bw_r) && $stable(act_mode_r);
  endproperty
  a_mid_field: assert property (p_mid_field) else $error("settings changed mid field");

  property p_mono;
    take && !eff_bw[ROUTE_BIT] && !eff_ff[FORMAT_BIT] |=> o_dac.ch0 == o_dac.ch1 && !o_rgb_mode;
  endproperty
  a_mono: assert property (p_mono) else $error("composite not mono");

  property p_defeat;
    take && eff_bw[DEFEAT_BIT] && fifo_pix.vblank |=> o_luma_taps == $past(min_luma_taps);
  endproperty
  a_defeat: assert property (p_defeat) else $error("blanking defeat ignored");

  property p_defeat_dot;
    take && eff_bw[DEFEAT_BIT] && fifo_pix.vblank |=> !o_dot_crawl && o_chroma_taps == $past(min_luma_taps);
  endproperty
  a_defeat_dot: assert property (p_defeat_dot) else $error("chroma not minimal in blanking");

  property p_lock;
    s_field_take ##0 eff_bw[LOCK_BIT] |=> phase_r == 2'h1 && o_subcarrier_locked;
  endproperty
  a_lock: assert property (p_lock) else $error("subcarrier not restarted");

  property p_half_taps;
    take && rc == RC_HALF && lsel == 2'h3 |=> o_luma_taps == 3'h7;
  endproperty
  a_half_taps: assert property (p_half_taps) else $error("half ratio taps wrong");

  property p_58_chroma;
    take && rc == RC_58 && csel == 2'h3 |=> o_chroma_taps == 3'h5 && o_dot_crawl == $past(dot_en);
  endproperty
  a_58_chroma: assert property (p_58_chroma) else $error("5/8 chroma taps wrong");

  property p_hold;
    s_stall |=> o_dac_valid && $stable(o_dac);
  endproperty
  a_hold: assert property (p_hold) else $error("output dropped under stall");

endmodule : tv_flicker_bandwidth_control

// [dac_sink_model.sv]
`timescale 1ns/1ps
module dac_sink_model #(
  parameter int SEED = 91
) (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_nrst,
  // bench control
  input  wire logic i_stall,
  // dac stream acceptance
  output logic      o_ready
);
  // ********************************
  // random acceptance
  // ********************************
  // readiness is drawn fresh each cycle so the output side meets both quick and slow takers
  int seed = SEED;
  initial o_ready = 1'b0;
  always @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      o_ready <= 1'b0;
    else
      o_ready <= #2 !i_stall && ($random(seed) % 4 != 0);
  end
endmodule : dac_sink_model

// [tb_tv_flicker_bandwidth_control.sv]
`timescale 1ns/1ps
module tb_tv_flicker_bandwidth_control;
  import tv_filter_pkg::*;
  localparam int DEPTH = 8;
  localparam int LIMIT = 6000;
  typedef struct {
    logic [1:0]  std;
    logic        rgb;
    logic [2:0]  lt;
    logic [2:0]  ct;
    logic        dot;
    logic        lock;
    logic        same;
    logic [29:0] raw;
  } exp_t;
  logic       i_clk       = 1'b0;
  logic       i_nrst      = 1'b0;
  logic       i_reg_wr    = 1'b0;
  logic [7:0] i_reg_addr  = 8'h00;
  logic [7:0] i_reg_wdata = 8'h00;
  logic [7:0] o_reg_rdata;
  pixel_t     i_pix       = '0;
  logic       i_pix_valid = 1'b0;
  logic       o_pix_ready;
  dac_t       o_dac;
  logic       o_dac_valid;
  logic       dac_ready;
  video_std_t o_video_std;
  logic       o_rgb_mode;
  logic [2:0] o_luma_taps;
  logic [2:0] o_chroma_taps;
  logic       o_dot_crawl;
  logic       o_subcarrier_locked;
  logic       stall       = 1'b1;
  exp_t       notes[$];
  exp_t       got_e;
  int         mismatches  = 0;
  int         n_tests     = 0;
  int         seed        = 91;
  int         cycles      = 0;
  int         accepted    = 0;
  int         base;
  logic [5:0] modes[7]    = '{6'o30, 6'o31, 6'o35, 6'o76, 6'o77, 6'o36, 6'o37};
  // written copies and the copies active for the current field
  logic [7:0] mode_w      = MODE_RESET;
  logic [7:0] ff_w        = FLICKER_RESET;
  logic [7:0] bw_w        = BANDWIDTH_RESET;
  logic [7:0] mode_a      = MODE_RESET;
  logic [7:0] ff_a        = FLICKER_RESET;
  logic [7:0] bw_a        = BANDWIDTH_RESET;

  always #20 i_clk = ~i_clk;

  tv_flicker_bandwidth_control #(.FIFO_DEPTH(DEPTH)) uut (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_reg_wr(i_reg_wr), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .i_pix(i_pix), .i_pix_valid(i_pix_valid),
    .o_pix_ready(o_pix_ready), .o_dac(o_dac), .o_dac_valid(o_dac_valid), .i_dac_ready(dac_ready),
    .o_video_std(o_video_std), .o_rgb_mode(o_rgb_mode), .o_luma_taps(o_luma_taps),
    .o_chroma_taps(o_chroma_taps), .o_dot_crawl(o_dot_crawl), .o_subcarrier_locked(o_subcarrier_locked));

  dac_sink_model #(.SEED(91)) sink (.i_clk(i_clk), .i_nrst(i_nrst), .i_stall(stall), .o_ready(dac_ready));

  // ********************************
  // helpers
  // ********************************
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      mismatches++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic step();
    @(posedge i_clk);
    #2;
  endtask : step

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    i_reg_addr = a;
    i_reg_wdata = d;
    i_reg_wr = 1'b1;
    step();
    i_reg_wr = 1'b0;
    if (a == MODE_REG_ADDR) mode_w = d;
    if (a == FLICKER_REG_ADDR) ff_w = d & FLICKER_MASK;
    if (a == BANDWIDTH_REG_ADDR) bw_w = d;
    step();
  endtask : wr_reg

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    i_reg_addr = a;
    step();
    chk(o_reg_rdata, exp);
  endtask : rd_chk

  function automatic logic [2:0] taps(input logic [1:0] sel, input logic chroma);
    logic big;
    big = mode_a[7:5] == 3'b111;
    case (mode_a[2:0])
      3'b000:  return (sel == 2'b00) ? 3'd2 : 3'd3;
      3'b101:  return (sel == 2'b11 && !chroma) ? 3'd6 : 3'd2 + sel;
      3'b110:  return big ? 3'd3 + sel : 3'd2 + sel;
      3'b111:  return !big ? 3'd2 + sel : (sel == 2'b00 ? 3'd3 : (sel == 2'b11 ? 3'd7 : 3'd5));
      default: return 3'd2 + sel;
    endcase
  endfunction : taps

  // hold keeps valid raised so the next pixel follows back to back
  task automatic send_pix(input logic fs, input logic hold);
    pixel_t p;
    exp_t   e;
    logic   blank;
    p = '0;
    {p.y, p.cb, p.cr} = 30'($random(seed));
    p.text = 1'($random(seed));
    p.vblank = ($random(seed) % 4 == 0);
    p.field_start = fs;
    if (fs)
    begin
      mode_a = mode_w;
      ff_a = ff_w;
      bw_a = bw_w;
    end
    blank = p.vblank && bw_a[DEFEAT_BIT];
    e.lt = taps(blank ? 2'b00 : (p.text ? ff_a[3:2] : ff_a[1:0]), 1'b0);
    e.ct = taps(blank ? 2'b00 : ff_a[5:4], 1'b1);
    e.dot = !blank && ff_a[5:4] == 2'b11;
    e.std = mode_a[4:3];
    e.rgb = ff_a[FORMAT_BIT];
    e.lock = bw_a[LOCK_BIT];
    e.same = !ff_a[FORMAT_BIT] && !bw_a[ROUTE_BIT];
    e.raw = {p.y, p.cb, p.cr};
    i_pix = p;
    i_pix_valid = 1'b1;
    while (o_pix_ready !== 1'b1) step();
    step();
    accepted++;
    notes.push_back(e);
    if (!hold) i_pix_valid = 1'b0;
    if (!hold) step();
  endtask : send_pix

  // ********************************
  // output watcher and timeout
  // ********************************
  always @(posedge i_clk)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      mismatches++;
      stop_test();
    end
    if (i_nrst && o_dac_valid === 1'b1 && dac_ready === 1'b1)
    begin
      if (notes.size() == 0)
        chk(32'h0000_0000, 32'h0000_0001);
      else
      begin
        got_e = notes.pop_front();
        chk(o_video_std, got_e.std);
        chk(o_rgb_mode, got_e.rgb);
        chk(o_luma_taps, got_e.lt);
        chk(o_chroma_taps, got_e.ct);
        chk(o_dot_crawl, got_e.dot);
        chk(o_subcarrier_locked, got_e.lock);
        if (got_e.rgb)
          chk(o_dac, got_e.raw);
        else if (got_e.same)
          chk(o_dac.ch0, o_dac.ch1);
      end
    end
  end

  // ********************************
  // main sequence
  // ********************************
  initial
  begin
    repeat (6) @(posedge i_clk);
    #2;
    i_nrst = 1'b1;
    step();
    stall = 1'b0;
    rd_chk(MODE_REG_ADDR, 8'h6A);
    rd_chk(FLICKER_REG_ADDR, 8'h27);
    rd_chk(BANDWIDTH_REG_ADDR, 8'h1E);
    wr_reg(8'h03, 8'h55);
    rd_chk(8'h03, 8'h00);
    wr_reg(FLICKER_REG_ADDR, 8'hFF);
    rd_chk(FLICKER_REG_ADDR, 8'h7F);
    foreach (modes[i])
      for (int k = 0; k < 4; k++)
      begin
        wr_reg(MODE_REG_ADDR, {modes[i][5:3], 2'(k), modes[i][2:0]});
        wr_reg(FLICKER_REG_ADDR, {1'b0, 1'($random(seed)), 2'(k), 2'(3 - k), 2'(k)});
        wr_reg(BANDWIDTH_REG_ADDR, 8'($random(seed)));
        send_pix(1'b0, 1'b0);
        send_pix(1'b1, 1'b0);
        send_pix(1'b0, 1'b0);
        send_pix(1'b0, 1'b0);
      end
    // the sink stalls while pixels arrive back to back until the buffer refuses
    while (notes.size() != 0) step();
    stall = 1'b1;
    base = accepted;
    fork
      begin
        repeat (60) step();
        chk((accepted - base >= DEPTH) && (accepted - base <= DEPTH + 3), 1);
        stall = 1'b0;
      end
      begin
        for (int j = 0; j < 16; j++) send_pix(j == 0, 1'b1);
        i_pix_valid = 1'b0;
      end
    join
    while (notes.size() != 0) step();
    stop_test();
  end
endmodule : tb_tv_flicker_bandwidth_control
